// File: core/clock_fault_monitor.sv
// Clock fault monitor: signal loss, frequency range and lock supervision.
// Assumes all watched clocks are sampled levels well below clk / 2.
//
// Local design decisions: the register offsets and the strobed register port.
`timescale 1ns/1ps
`include "clock_fault_regs.svh"

// How it works
// - One ramp rate serves switching and holdover exit.
// - Ramped switching is a selectable control bit.
// - Accept input switch only within 40 ppm.
// - Lock lost stays set during pull-in.
// - Four inputs: loss and frequency; oscillator: loss.
// - Per-source period timer with programmable limit.
// - Live and sticky loss bits, per-source disable.
// - Oscillator loss gates outputs unless overridden.
// - Frequency reference: oscillator or any input.
// - Precise and fast results combine, each disableable.
// - Live and sticky frequency status bits.
// - Precise threshold in 1/16 ppm, to 511 ppm.
// - Precise monitor uses assert/deassert hysteresis.
// - Fast threshold 1000 to 16000 ppm.
// - Lock lost bit and pin per channel.
// - Separate set and clear frequency monitors.
// - Set and clear thresholds in 0.1 ppm steps.
// - Optional delay before lock lost clears.
// - Live and sticky lock lost per channel.
// - Unmasked status events drive the interrupt.
// - Interrupt ends only when sticky bits are cleared or masked.
// - Ramp rate index spans forty values.
module clock_fault_monitor
	import clock_fault_pkg::*;
#(
	parameter int N_PLL = 4,
	parameter int LOSS_W = 16,
	parameter int PREC_LOG = 20,
	parameter int FAST_LOG = 10,
	parameter int LOCK_LOG = 16
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic srst,
	// Register port.
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// Watched clocks, taken as levels.
	input wire logic clk_input_0,
	input wire logic clk_input_1,
	input wire logic clk_input_2,
	input wire logic clk_input_3,
	input wire logic ref_osc_pins,
	// PLL channel side.
	input wire logic [N_PLL-1:0] pll_feedback,
	input wire logic [N_PLL-1:0] pll_holdover,
	output logic [N_PLL-1:0][1:0] pll_input,
	output logic [N_PLL-1:0] lock_lost,
	output logic [N_PLL-1:0] fast_bw,
	output logic [N_PLL-1:0] ramp_start,
	output logic ramp_mode,
	output logic [5:0] ramp_rate,
	// Device level status.
	output logic out_enable,
	output logic ref_osc_signal_loss,
	output logic irq_out_n
);

	// ----------------------------------------
	// Parameter checks and sizes
	// ----------------------------------------
	if (N_PLL < 1 || N_PLL > 4 || LOSS_W < 2 || LOSS_W > 32 ||
		PREC_LOG < 2 || PREC_LOG > 28 || FAST_LOG < 2 ||
		FAST_LOG > 28 || LOCK_LOG < 2 || LOCK_LOG > 28) begin : g_bad
		$error("clock_fault_monitor: unsupported parameters");
	end

	localparam int PW = PREC_LOG + 2;
	localparam int FW = FAST_LOG + 2;
	localparam int KW = LOCK_LOG + 2;
	localparam logic [31:0] PGATE = 32'(1) << PREC_LOG;
	localparam logic [31:0] FGATE = 32'(1) << FAST_LOG;
	localparam logic [31:0] KGATE = 32'(1) << LOCK_LOG;

	// Entire state of the block.
	typedef struct packed {
		logic [4:0] prev;
		logic [4:0][LOSS_W-1:0] loss_cnt;
		logic [4:0] loss;
		logic [PREC_LOG-1:0] pgate;
		logic [3:0][PW-1:0] pcnt;
		logic [3:0][PW-1:0] plat;
		logic [3:0] pflag;
		logic [FAST_LOG-1:0] fgate;
		logic [3:0][FW-1:0] fcnt;
		logic [3:0] fflag;
		logic [N_PLL-1:0] fbprev;
		logic [N_PLL-1:0] hold_prev;
		logic [N_PLL-1:0][LOCK_LOG-1:0] kgate;
		logic [N_PLL-1:0][KW-1:0] kfb;
		logic [N_PLL-1:0][7:0] kdly;
		logic [N_PLL-1:0] lost;
		logic [N_PLL-1:0][1:0] act;
		logic [N_PLL-1:0] ramp;
		ctrl_t ctrl;
		logic [4:0] loss_en;
		logic [5:0] rate;
		logic [12:0] f_assert;
		logic [12:0] f_hyst;
		logic [4:0] fast_thr;
		logic [16:0] k_set;
		logic [16:0] k_clr;
		logic [7:0] k_delay;
		logic [N_PLL-1:0][1:0] sel;
		logic [4:0][LOSS_W-1:0] loss_thr;
		status_t sticky;
		status_t mask;
		logic [31:0] rdata;
		logic oen;
		logic irq_n;
	} state_t;

	state_t s_reg;
	state_t s_next;
	logic [4:0] src;
	logic [4:0] edges;
	logic [3:0] freq_live;
	status_t live;

	// ----------------------------------------
	// Helper functions
	// ----------------------------------------

	// Distance between two counts, order free.
	function automatic logic [31:0] adiff(input logic [31:0] a,
		input logic [31:0] b);
		return (a > b) ? a - b : b - a;
	endfunction : adiff

	// True when err/gate exceeds thr in units set by scale.
	// Wide products keep the ppm comparison exact, no division.
	function automatic logic over(input logic [31:0] err,
		input logic [31:0] thr, input logic [31:0] scale,
		input int lg);
		return (64'(err) * 64'(scale)) > (64'(thr) << lg);
	endfunction : over

	// Maps the reference select code to a source index.
	function automatic logic [2:0] ref_index(input logic [2:0] code);
		return (code > `OSC_IDX) ? `OSC_IDX : code;
	endfunction : ref_index

	// ----------------------------------------
	// Sources and status view
	// ----------------------------------------
	assign src = {ref_osc_pins, clk_input_3, clk_input_2, clk_input_1,
		clk_input_0};
	assign edges = src & ~s_reg.prev;

	// Either monitor may be switched off alone.
	assign freq_live = ({4{s_reg.ctrl.prec_en}} & s_reg.pflag) |
		({4{s_reg.ctrl.fast_en}} & s_reg.fflag);

	// Live word, one layout for live, sticky and mask.
	always_comb begin
		live = '0;
		live.sig_loss = s_reg.loss;
		live.freq_bad = freq_live;
		live.lock_lost[N_PLL-1:0] = s_reg.lost;
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		logic ref_edge;
		logic pd_edge;
		logic fb_edge;
		logic [31:0] err;
		logic [31:0] deassert;
		logic [31:0] clr;
		logic [5:0] rate_w;
		logic [4:0] fthr_w;
		logic [1:0] pd;
		logic [1:0] cand;
		ref_edge = 1'b0;
		pd_edge = 1'b0;
		fb_edge = 1'b0;
		err = '0;
		deassert = '0;
		clr = '0;
		rate_w = '0;
		fthr_w = '0;
		pd = '0;
		cand = '0;
		s_next = s_reg;
		s_next.ramp = '0;
		s_next.rdata = '0;
		s_next.prev = src;
		s_next.fbprev = pll_feedback;
		s_next.hold_prev = pll_holdover;

		// Period timers: any rising edge restarts, a silent span past the
		// limit flags loss. A high limit rides out isolated gaps.
		for (int i = 0; i < 5; i++) begin
			if (!s_reg.loss_en[i]) begin
				s_next.loss_cnt[i] = '0;
				s_next.loss[i] = 1'b0;
			end else if (edges[i]) begin
				s_next.loss_cnt[i] = '0;
				s_next.loss[i] = 1'b0;
			end else if (s_reg.loss_cnt[i] >= s_reg.loss_thr[i]) begin
				s_next.loss[i] = 1'b1;
			end else begin
				s_next.loss_cnt[i] = s_reg.loss_cnt[i] + 1'b1;
			end
		end

		// Frequency gates run on the selected zero-ppm reference.
		ref_edge = edges[ref_index(s_reg.ctrl.freq_ref)];
		if (s_reg.f_assert > s_reg.f_hyst) begin
			deassert = 32'(s_reg.f_assert - s_reg.f_hyst);
		end
		if (ref_edge) begin
			s_next.pgate = s_reg.pgate + 1'b1;
			s_next.fgate = s_reg.fgate + 1'b1;
		end
		for (int i = 0; i < 4; i++) begin
			// Counters saturate so a wild input cannot wrap back.
			if (edges[i] && !(&s_reg.pcnt[i])) begin
				s_next.pcnt[i] = s_reg.pcnt[i] + 1'b1;
			end
			if (edges[i] && !(&s_reg.fcnt[i])) begin
				s_next.fcnt[i] = s_reg.fcnt[i] + 1'b1;
			end
			// Long gate: fine measurement with hysteresis.
			if (ref_edge && (&s_reg.pgate)) begin
				err = adiff(32'(s_next.pcnt[i]), PGATE);
				s_next.plat[i] = s_next.pcnt[i];
				s_next.pcnt[i] = '0;
				if (!s_reg.pflag[i]) begin
					s_next.pflag[i] = over(err, 32'(s_reg.f_assert),
						`SCALE_PREC, PREC_LOG);
				end else begin
					s_next.pflag[i] = over(err, deassert,
						`SCALE_PREC, PREC_LOG);
				end
			end
			// Short gate: coarse but quick, catches ramping inputs.
			if (ref_edge && (&s_reg.fgate)) begin
				err = adiff(32'(s_next.fcnt[i]), FGATE);
				s_next.fcnt[i] = '0;
				s_next.fflag[i] = over(err, 32'(s_reg.fast_thr),
					`SCALE_FAST, FAST_LOG);
			end
		end

		// Lock supervision per channel at the phase detector.
		for (int p = 0; p < N_PLL; p++) begin
			pd = s_reg.act[p];
			cand = s_reg.sel[p];
			pd_edge = edges[pd];
			fb_edge = pll_feedback[p] & ~s_reg.fbprev[p];
			if (pd_edge) begin
				s_next.kgate[p] = s_reg.kgate[p] + 1'b1;
			end
			if (fb_edge && !(&s_reg.kfb[p])) begin
				s_next.kfb[p] = s_reg.kfb[p] + 1'b1;
			end
			if (pd_edge && (&s_reg.kgate[p])) begin
				err = adiff(32'(s_next.kfb[p]), KGATE);
				s_next.kfb[p] = '0;
				if (over(err, 32'(s_reg.k_set), `SCALE_LOCK,
					LOCK_LOG)) begin
					s_next.lost[p] = 1'b1;
					s_next.kdly[p] = '0;
				end else if (s_reg.lost[p] && !over(err,
					32'(s_reg.k_clr), `SCALE_LOCK, LOCK_LOG)) begin
					// Clear holds off for k_delay further good gates.
					if (s_reg.kdly[p] >= s_reg.k_delay) begin
						s_next.lost[p] = 1'b0;
						s_next.kdly[p] = '0;
					end else begin
						s_next.kdly[p] = s_reg.kdly[p] + 1'b1;
					end
				end else begin
					s_next.kdly[p] = '0;
				end
			end
			// A dead phase-detector input is never locked.
			if (s_reg.loss[pd]) begin
				s_next.lost[p] = 1'b1;
				s_next.kdly[p] = '0;
			end
			// Switch only to a live input within the pull range.
			if (cand != pd && !s_reg.loss[cand] &&
				!over(adiff(32'(s_reg.plat[cand]),
				32'(s_reg.plat[pd])), `SWITCH_PPM, `SCALE_PPM,
				PREC_LOG)) begin
				s_next.act[p] = cand;
				s_next.lost[p] = 1'b1;
				s_next.kdly[p] = '0;
				s_next.kgate[p] = '0;
				s_next.kfb[p] = '0;
				s_next.ramp[p] = s_reg.ctrl.ramp_en;
			end
			// Holdover exit uses the same ramp settings.
			if (s_reg.hold_prev[p] && !pll_holdover[p]) begin
				s_next.ramp[p] = s_reg.ctrl.ramp_en;
			end
		end

		// Register writes.
		if (reg_wr) begin
			case (reg_addr)
				`ADDR_CTRL: s_next.ctrl = ctrl_t'(8'(reg_wdata));
				`ADDR_LOSS_EN: s_next.loss_en = 5'(reg_wdata);
				`ADDR_RAMP_RATE: begin
					rate_w = 6'(reg_wdata);
					s_next.rate = (rate_w > `RAMP_IDX_MAX) ?
						`RAMP_IDX_MAX : rate_w;
				end
				`ADDR_FREQ_ASSERT: s_next.f_assert = 13'(reg_wdata);
				`ADDR_FREQ_HYST: s_next.f_hyst = 13'(reg_wdata);
				`ADDR_FAST_THR: begin
					fthr_w = 5'(reg_wdata);
					if (fthr_w < `FAST_THR_MIN) begin
						s_next.fast_thr = `FAST_THR_MIN;
					end else if (fthr_w > `FAST_THR_MAX) begin
						s_next.fast_thr = `FAST_THR_MAX;
					end else begin
						s_next.fast_thr = fthr_w;
					end
				end
				`ADDR_LOCK_SET: s_next.k_set = 17'(reg_wdata);
				`ADDR_LOCK_CLR: s_next.k_clr = 17'(reg_wdata);
				`ADDR_LOCK_DELAY: s_next.k_delay = 8'(reg_wdata);
				`ADDR_PLL_SEL: s_next.sel = reg_wdata[2*N_PLL-1:0];
				`ADDR_STICKY: clr = reg_wdata;
				`ADDR_MASK: s_next.mask = status_t'(reg_wdata);
				default: ;
			endcase
			for (int i = 0; i < 5; i++) begin
				if (reg_addr == `ADDR_LOSS_THR0 +
					8'(i) * `REG_STRIDE) begin
					s_next.loss_thr[i] = LOSS_W'(reg_wdata);
				end
			end
		end

		// Sticky bits: a live condition wins over a clear.
		s_next.sticky = status_t'((32'(s_reg.sticky) & ~clr) |
			32'(live));

		// Interrupt follows unmasked sticky bits, low when active.
		s_next.irq_n = ~|(32'(s_next.sticky) &
			~32'(s_next.mask));

		// Oscillator failure disables outputs unless kept on.
		s_next.oen = ~s_next.loss[`OSC_IDX] |
			s_next.ctrl.keep_outputs;

		// Register reads answer in the next cycle only.
		if (reg_rd) begin
			case (reg_addr)
				`ADDR_CTRL: s_next.rdata = 32'(s_reg.ctrl);
				`ADDR_LOSS_EN: s_next.rdata = 32'(s_reg.loss_en);
				`ADDR_RAMP_RATE: s_next.rdata = 32'(s_reg.rate);
				`ADDR_FREQ_ASSERT: s_next.rdata = 32'(s_reg.f_assert);
				`ADDR_FREQ_HYST: s_next.rdata = 32'(s_reg.f_hyst);
				`ADDR_FAST_THR: s_next.rdata = 32'(s_reg.fast_thr);
				`ADDR_LOCK_SET: s_next.rdata = 32'(s_reg.k_set);
				`ADDR_LOCK_CLR: s_next.rdata = 32'(s_reg.k_clr);
				`ADDR_LOCK_DELAY: s_next.rdata = 32'(s_reg.k_delay);
				`ADDR_PLL_SEL: s_next.rdata = 32'(s_reg.sel);
				`ADDR_LIVE: s_next.rdata = 32'(live);
				`ADDR_STICKY: s_next.rdata = 32'(s_reg.sticky);
				`ADDR_MASK: s_next.rdata = 32'(s_reg.mask);
				default: s_next.rdata = '0;
			endcase
			for (int i = 0; i < 5; i++) begin
				if (reg_addr == `ADDR_LOSS_THR0 +
					8'(i) * `REG_STRIDE) begin
					s_next.rdata = 32'(s_reg.loss_thr[i]);
				end
			end
		end
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (srst) begin
			s_reg <= '0;
			s_reg.ctrl <= ctrl_t'(`CTRL_RST);
			s_reg.loss_en <= `LOSS_EN_RST;
			s_reg.f_assert <= `FREQ_ASSERT_RST;
			s_reg.f_hyst <= `FREQ_HYST_RST;
			s_reg.fast_thr <= `FAST_THR_RST;
			s_reg.k_set <= `LOCK_SET_RST;
			s_reg.k_clr <= `LOCK_CLR_RST;
			s_reg.loss_thr <= {5{LOSS_W'(`LOSS_THR_RST)}};
			s_reg.lost <= '1;
			s_reg.oen <= 1'b1;
			s_reg.irq_n <= 1'b1;
		end else begin
			s_reg <= s_next;
		end
	end

	// ----------------------------------------
	// Outputs, all from the state register
	// ----------------------------------------
	assign reg_rdata = s_reg.rdata;
	assign pll_input = s_reg.act;
	assign lock_lost = s_reg.lost;
	assign fast_bw = s_reg.lost & {N_PLL{s_reg.ctrl.fastlock_en}};
	assign ramp_start = s_reg.ramp;
	assign ramp_mode = s_reg.ctrl.ramp_en;
	assign ramp_rate = s_reg.rate;
	assign out_enable = s_reg.oen;
	assign ref_osc_signal_loss = s_reg.loss[`OSC_IDX];
	assign irq_out_n = s_reg.irq_n;

endmodule : clock_fault_monitor

// File: core/clock_fault_regs.svh
// Register map, reset values and scale constants of the clock fault monitor.
// Assumes a 32-bit register port with an 8-bit byte address.
`ifndef CLOCK_FAULT_REGS_SVH
`define CLOCK_FAULT_REGS_SVH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define ADDR_CTRL 8'h00
`define ADDR_LOSS_EN 8'h04
`define ADDR_RAMP_RATE 8'h08
`define ADDR_FREQ_ASSERT 8'h0c
`define ADDR_FREQ_HYST 8'h10
`define ADDR_FAST_THR 8'h14
`define ADDR_LOCK_SET 8'h18
`define ADDR_LOCK_CLR 8'h1c
`define ADDR_LOCK_DELAY 8'h20
`define ADDR_PLL_SEL 8'h24
`define ADDR_LOSS_THR0 8'h28
`define ADDR_LIVE 8'h40
`define ADDR_STICKY 8'h44
`define ADDR_MASK 8'h48
`define REG_STRIDE 8'h04

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CTRL_RST 8'h99
`define LOSS_EN_RST 5'h1f
`define FREQ_ASSERT_RST 13'h03c0
`define FREQ_HYST_RST 13'h0020
`define FAST_THR_RST 5'h01
`define LOCK_SET_RST 17'h0000a
`define LOCK_CLR_RST 17'h00001
`define LOSS_THR_RST 32'h00000100

// ----------------------------------------
// Limits and scale factors
// ----------------------------------------
`define FAST_THR_MIN 5'h01
`define FAST_THR_MAX 5'h10
`define RAMP_IDX_MAX 6'h27
`define OSC_IDX 3'h4
`define SCALE_PREC 32'h00f42400
`define SCALE_FAST 32'h000003e8
`define SCALE_LOCK 32'h00989680
`define SCALE_PPM 32'h000f4240
`define SWITCH_PPM 32'h00000028

`endif

// File: core/clock_fault_pkg.sv
// Types shared by the clock fault monitor and its bench.
// Assumes at most four PLL channels and five watched clock sources.
package clock_fault_pkg;

	// Control word: reference select, monitor enables, ramp options.
	typedef struct packed {
		logic [2:0] freq_ref;
		logic fast_en;
		logic prec_en;
		logic fastlock_en;
		logic keep_outputs;
		logic ramp_en;
	} ctrl_t;

	// Status word layout shared by live, sticky and mask registers.
	typedef struct packed {
		logic [11:0] spare_hi;
		logic [3:0] lock_lost;
		logic [3:0] spare_mid;
		logic [3:0] freq_bad;
		logic [2:0] spare_lo;
		logic [4:0] sig_loss;
	} status_t;

endpackage : clock_fault_pkg

// File: bench/clock_fault_assertions.sv
// Port checks on the clock fault monitor.
// Assumes it is bound to every clock_fault_monitor instance.
`timescale 1ns/1ps
module clock_fault_assertions #(
	parameter int N_PLL = 4
) (
	// Clock, reset and register writes.
	input wire logic clk,
	input wire logic srst,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	// Oscillator and PLL side.
	input wire logic ref_osc_pins,
	input wire logic [N_PLL-1:0][1:0] pll_input,
	input wire logic [N_PLL-1:0] lock_lost,
	input wire logic [N_PLL-1:0] fast_bw,
	input wire logic [N_PLL-1:0] ramp_start,
	input wire logic ramp_mode,
	input wire logic [5:0] ramp_rate,
	// Device status.
	input wire logic out_enable,
	input wire logic ref_osc_signal_loss,
	input wire logic irq_out_n
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	// A switch on channel 0 is seen as a change of its input index.
	sequence switch_seen;
		$changed(pll_input[0]);
	endsequence

	reset_state_a:
	assert property ($fell(srst) |-> &lock_lost && irq_out_n && out_enable)
	else $error("state after reset wrong");
	fast_bw_gate_a:
	assert property ((fast_bw & ~lock_lost) == '0)
	else $error("fast bandwidth without lock lost");
	ramp_gate_a:
	assert property (|ramp_start |-> ramp_mode)
	else $error("ramp start while ramping off");
	ramp_pulse_a:
	assert property ((ramp_start & $past(ramp_start)) == '0)
	else $error("ramp start longer than a cycle");
	ramp_range_a:
	assert property (ramp_rate <= 6'd39)
	else $error("ramp rate beyond range");
	switch_lost_a:
	assert property (switch_seen |-> ##[0:1] lock_lost[0])
	else $error("switch without lock lost");
	out_gate_a:
	assert property (!out_enable |->
		ref_osc_signal_loss || $past(ref_osc_signal_loss))
	else $error("outputs off without oscillator loss");
	irq_release_a:
	assert property ($rose(irq_out_n) |-> $past(reg_wr) &&
		$past(reg_addr) inside {8'h44, 8'h48})
	else $error("interrupt ended without a clear");
	osc_loss_a:
	assert property ($rose(ref_osc_signal_loss) |->
		$past(ref_osc_pins, 2) == $past(ref_osc_pins))
	else $error("oscillator loss while toggling");
endmodule : clock_fault_assertions

bind clock_fault_monitor clock_fault_assertions #(.N_PLL(N_PLL)) chk_u (
	.clk, .srst, .reg_addr, .reg_wr, .ref_osc_pins, .pll_input,
	.lock_lost, .fast_bw, .ramp_start, .ramp_mode, .ramp_rate,
	.out_enable, .ref_osc_signal_loss, .irq_out_n);

// File: bench/clock_source_model.sv
// Clock sources: four inputs, the oscillator and channel 0 feedback.
// Assumes half periods of at least 2 clk cycles.
`timescale 1ns/1ps
module clock_source_model (
	// Counter clock.
	input wire logic clk,
	// Per source run enable and half period in clk cycles.
	input wire logic [5:0] run,
	input wire logic [5:0][3:0] half,
	// Source levels.
	output logic [5:0] lvl
);
	logic [5:0][3:0] cnt;

	// A stopped source freezes, as a dead oscillator does.
	initial begin
		lvl = '0;
		cnt = '0;
	end
	always @(posedge clk) begin
		for (int i = 0; i < 6; i++) begin
			if (run[i] && cnt[i] + 4'd1 >= half[i]) begin
				cnt[i] <= 4'd0;
				lvl[i] <= ~lvl[i];
			end else if (run[i]) begin
				cnt[i] <= cnt[i] + 4'd1;
			end
		end
	end
endmodule : clock_source_model

// File: bench/testbench.sv
// Self-checking bench of the clock fault monitor.
// Assumes short gate parameters so precise and lock gates span 128 cycles, the fast gate 64.
`timescale 1ns/1ps
module testbench;
	import clock_fault_pkg::*;
	logic clk, srst, reg_wr, reg_rd, ramp_mode, out_enable;
	logic ref_osc_signal_loss, irq_out_n;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, v;
	logic [3:0] lock_lost, fast_bw, ramp_start, hold;
	logic [3:0][1:0] pll_input;
	logic [5:0] ramp_rate, run, lvl;
	logic [5:0][3:0] half;
	int n_mismatch, n_tests;
	// Reset values; the 60 ppm precise frequency threshold is kept.
	logic [7:0] ra [10] = '{8'h00, 8'h04, 8'h0c, 8'h10, 8'h14, 8'h18,
		8'h1c, 8'h28, 8'h48, 8'h80};
	logic [31:0] re [10] = '{32'h99, 32'h1f, 32'h3c0, 32'h20, 32'h1,
		32'ha, 32'h1, 32'h100, 32'h0, 32'h0};

	clock_source_model src_u (.clk(clk), .run(run), .half(half), .lvl(lvl));
	clock_fault_monitor #(.PREC_LOG(4), .FAST_LOG(3), .LOCK_LOG(4)) dut_u (
		.clk(clk), .srst(srst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .clk_input_0(lvl[0]),
		.clk_input_1(lvl[1]), .clk_input_2(lvl[2]),
		.clk_input_3(lvl[3]), .ref_osc_pins(lvl[4]),
		.pll_feedback({lvl[0], lvl[0], lvl[0], lvl[5]}),
		.pll_holdover(hold), .pll_input(pll_input),
		.lock_lost(lock_lost), .fast_bw(fast_bw),
		.ramp_start(ramp_start), .ramp_mode(ramp_mode),
		.ramp_rate(ramp_rate), .out_enable(out_enable),
		.ref_osc_signal_loss(ref_osc_signal_loss),
		.irq_out_n(irq_out_n));

	// -------------------------------------------
	// Helpers
	// -------------------------------------------
	// The clock runs at 200 MHz.
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string what);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr

	// Read data stand only in the cycle after the read edge.
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask : rd

	// Bounded wait for a one-cycle ramp start pulse.
	task automatic wait_ramp(input int ch);
		int k;
		k = 0;
		while (ramp_start[ch] !== 1'b1 && k < 900) begin
			tick(1);
			k++;
		end
		chk(k < 900, 1, "ramp start");
	endtask : wait_ramp

	task automatic close_out;
		$display("Checks %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : close_out

	// -------------------------------------------
	// Scenarios
	// -------------------------------------------
	task automatic t_reset;
		chk(lock_lost, 4'hf, "lock after reset");
		tick(3);
		chk(irq_out_n, 0, "irq low");
		for (int i = 0; i < 10; i++) begin
			rd(ra[i]);
			chk(v, re[i], "reset value");
		end
	endtask : t_reset

	task automatic t_ramp;
		wr(8'h08, 32'h3f);
		rd(8'h08);
		chk(v, 32'h27, "ramp clamp");
		wr(8'h14, 32'h0);
		rd(8'h14);
		chk(v, 32'h1, "fast min");
		wr(8'h14, 32'h1f);
		rd(8'h14);
		chk(v, 32'h10, "fast max");
		wr(8'h00, 32'h98);
		tick(3);
		chk(ramp_mode, 0, "ramp off");
		wr(8'h00, 32'h99);
		@(posedge clk);
		hold[3] <= 1'b1;
		tick(4);
		hold[3] <= 1'b0;
		wait_ramp(3);
		chk(ramp_rate, 6'h27, "shared rate");
	endtask : t_ramp

	// Input 1 stops; the sticky bit survives a clear while live.
	task automatic t_loss;
		wr(8'h2c, 32'd20);
		@(posedge clk);
		run[1] <= 1'b0;
		tick(60);
		rd(8'h40);
		chk(v[1], 1, "live loss");
		wr(8'h44, 32'h2);
		rd(8'h44);
		chk(v[1], 1, "sticky kept");
		wr(8'h04, 32'h1d);
		tick(3);
		rd(8'h40);
		chk(v[1], 0, "loss disabled");
		wr(8'h04, 32'h1f);
		run[1] <= 1'b1;
		tick(40);
		wr(8'h44, 32'h2);
		rd(8'h44);
		chk(v[1], 0, "sticky cleared");
	endtask : t_loss

	task automatic t_osc;
		wr(8'h38, 32'd20);
		@(posedge clk);
		run[4] <= 1'b0;
		tick(60);
		chk(ref_osc_signal_loss, 1, "osc loss");
		chk(out_enable, 0, "outputs off");
		wr(8'h00, 32'h9b);
		tick(3);
		chk(out_enable, 1, "outputs kept");
		wr(8'h00, 32'h99);
		run[4] <= 1'b1;
		tick(40);
		wr(8'h44, 32'h10);
	endtask : t_osc

	// Input 2 runs at twice the nominal rate.
	task automatic t_freq;
		@(posedge clk);
		half[2] <= 4'd2;
		tick(600);
		rd(8'h44);
		chk(v[10], 1, "sticky freq");
		wr(8'h00, 32'h81);
		tick(600);
		rd(8'h40);
		chk(v[10], 0, "both off");
		wr(8'h00, 32'h91);
		tick(600);
		rd(8'h40);
		chk(v[10], 1, "fast only");
		wr(8'h00, 32'h59);
		tick(600);
		rd(8'h40);
		chk(v[11:8], 4'hb, "input 2 ref");
		half[2] <= 4'd4;
		wr(8'h00, 32'h99);
		tick(600);
		rd(8'h40);
		chk(v[11:8], 4'h0, "freq good");
		wr(8'h44, 32'hf00);
	endtask : t_freq

	task automatic t_lock;
		for (int k = 0; k < 3000 && lock_lost !== 4'h0; k++)
			tick(1);
		chk(lock_lost, 4'h0, "locked");
		wr(8'h20, 32'h3);
		wr(8'h00, 32'h9d);
		run[5] <= 1'b0;
		tick(300);
		chk(lock_lost[0], 1, "lost pin");
		chk(fast_bw[0], 1, "fast lock");
		rd(8'h40);
		chk(v[16], 1, "live lock");
		run[5] <= 1'b1;
		tick(300);
		chk(lock_lost[0], 1, "clear delayed");
		tick(900);
		chk(lock_lost[0], 0, "cleared");
		wr(8'h00, 32'h99);
	endtask : t_lock

	task automatic t_switch;
		wr(8'h24, 32'h1);
		wait_ramp(0);
		chk(pll_input[0], 2'd1, "switch");
		chk(lock_lost[0], 1, "pulling in");
		half[3] <= 4'd5;
		tick(600);
		wr(8'h24, 32'hd);
		tick(400);
		chk(pll_input[1], 2'd0, "switch refused");
		half[3] <= 4'd4;
		tick(900);
		chk(pll_input[1], 2'd3, "switch later");
		wr(8'h24, 32'h0);
	endtask : t_switch

	task automatic t_irq;
		wr(8'h48, 32'hffffffff);
		wr(8'h44, 32'hffffffff);
		tick(2);
		chk(irq_out_n, 1, "irq masked");
		wr(8'h48, 32'hfffffffd);
		run[1] <= 1'b0;
		tick(60);
		chk(irq_out_n, 0, "irq loss");
		run[1] <= 1'b1;
		tick(40);
		wr(8'h44, 32'h2);
		tick(2);
		chk(irq_out_n, 1, "irq cleared");
		wr(8'h48, 32'h0);
	endtask : t_irq

	// -------------------------------------------
	// Main sequence and watchdog
	// -------------------------------------------
	initial begin
		{srst, reg_wr, reg_rd, reg_addr, reg_wdata, hold} = '0;
		srst = 1'b1;
		run = '1;
		half = {6{4'd4}};
		repeat (5) @(posedge clk);
		srst <= 1'b0;
		tick(1);
		t_reset();
		t_ramp();
		t_loss();
		t_osc();
		t_freq();
		t_lock();
		t_switch();
		t_irq();
		close_out();
	end

	initial begin
		#200000;
		n_mismatch++;
		close_out();
	end
endmodule : testbench
